// ==== pad_pullup_control.sv ====
// Purpose: pad pull-up, direction and function control for bus and timer pins
// Assumes: apb slave on pclk, pins are asynchronous to pclk
// Notes:   outputs are registered copies of combinational pad logic
//
// Behaviour
// - bus receive: schmitt input, pull-up after reset
// - disable bit turns receive pull-up off
// - bus transmit: open drain, pull-up after reset
// - open drain driving low: pull-up off
// - open drain high: pull-up unless bit cleared
// - push pull output: pull-up always off
// - timer pins default to timer, pulled up
// - each port pin has own direction
// - cleared port pull-up bit disables pull-up
`include "pad_pullup_params.svh"
module pad_pullup_control
    import pad_pullup_pkg::*;
#(
    parameter int NPINS = 2                      // port e pins 8 and 9
)
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             can_rx_pin,       // bus receive pad level
    output logic                  can_rx_data,      // synchronised receive data
    output logic                  can_rx_pullup,    // receive pad pull-up enable
    input  wire logic             can_tx_ctl,       // transmit data from controller
    output logic                  can_tx_oe,        // transmit pad drives low
    output logic                  can_tx_out,       // transmit pad output level
    output logic                  can_tx_pullup,    // transmit pad pull-up enable
    input  wire logic [NPINS-1:0] timer_out,        // timer channel drive values
    input  wire logic [NPINS-1:0] timer_oe,         // timer channel output enables
    output logic      [NPINS-1:0] timer_in,         // synchronised pin to timer
    input  wire logic [NPINS-1:0] port_e_pin_in,    // timer_c_chan0/1 pad levels
    output logic      [NPINS-1:0] port_e_pin_out,   // pad output level
    output logic      [NPINS-1:0] port_e_pin_oe,    // pad output enable
    output logic      [NPINS-1:0] port_e_pullup     // pad pull-up enable
);
    logic             pullup_disable_reg;   // bit: receive pull-up off
    logic [NPINS-1:0] port_e_pullup_reg;    // port_pullup_enable_field
    logic [NPINS-1:0] func_gpio;            // 1 = general purpose, 0 = timer
    logic [NPINS-1:0] port_dir;             // 1 = output
    logic [NPINS-1:0] port_data;            // gpio output data
    logic [NPINS-1:0] port_open;            // 1 = open drain
    logic             can_tx_soft;          // software transmit bit, ANDed with can_tx_ctl
    logic             rx_meta;              // receive synchroniser stage 1
    logic             rx_sync;              // receive synchroniser stage 2
    logic [NPINS-1:0] pin_meta;             // port synchroniser stage 1
    logic [NPINS-1:0] pin_sync;             // port synchroniser stage 2
    logic [NPINS-1:0] next_pullup;          // per-pin effective pull-up
    logic [NPINS-1:0] next_oe;              // per-pin output enable
    logic [NPINS-1:0] eff_out;              // per-pin selected output
    logic [NPINS-1:0] eff_en;               // per-pin selected direction
    logic [NPINS-1:0] eff_open;             // per-pin selected mode
    logic             next_tx_pullup;       // transmit effective pull-up
    logic             next_tx_oe;           // transmit output enable
    logic             tx_val;               // transmit level
    logic             wr_en;                // apb write strobe
    logic [31:0]      next_prdata;          // read mux

    assign wr_en  = psel & penable & pwrite;
    assign tx_val = can_tx_ctl & can_tx_soft;

    // register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_disable_reg <= `RST_PULLUP_DISABLE;
            port_e_pullup_reg  <= NPINS'(`RST_PORT_E_PULLUP);
            func_gpio          <= NPINS'(`RST_PORT_E_FUNC);
            port_dir           <= NPINS'(`RST_PORT_E_DIR);
            port_data          <= NPINS'(`RST_PORT_E_DATA);
            port_open          <= NPINS'(`RST_PORT_E_OPEN);
            can_tx_soft        <= 1'b1;
        end
        else if (wr_en)
        begin
            case (paddr)
                `OFS_PULLUP_DISABLE: pullup_disable_reg <= pwdata[`BIT_PUD_CAN];
                `OFS_PORT_E_PULLUP:  port_e_pullup_reg  <= pwdata[NPINS-1:0];
                `OFS_PORT_E_FUNC:    func_gpio          <= pwdata[NPINS-1:0];
                `OFS_PORT_E_DIR:     port_dir           <= pwdata[NPINS-1:0];
                `OFS_PORT_E_DATA:    port_data          <= pwdata[NPINS-1:0];
                `OFS_PORT_E_OPEN:    port_open          <= pwdata[NPINS-1:0];
                `OFS_CAN_TX_DATA:    can_tx_soft        <= pwdata[0];
                default:             ;                   // unmapped: ignored
            endcase
        end
    end

    // two-flop synchronisers on pin inputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta  <= 1'b1;
            rx_sync  <= 1'b1;
            pin_meta <= '1;
            pin_sync <= '1;
        end
        else
        begin
            rx_meta  <= can_rx_pin;
            rx_sync  <= rx_meta;
            pin_meta <= port_e_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // function select: timer or gpio drives each pin
    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            if (func_gpio[i])
            begin
                eff_en[i]   = port_dir[i];
                eff_out[i]  = port_data[i];
                eff_open[i] = port_open[i];
            end
            else
            begin
                eff_en[i]   = timer_oe[i];
                eff_out[i]  = timer_out[i];
                eff_open[i] = 1'b0;
            end
        end
    end

    // one pad cell per port pin
    for (genvar g = 0; g < NPINS; g++)
    begin : g_pin
        pad_pullup_cell u_cell (
            .pullup_ctl (port_e_pullup_reg[g]),
            .out_en     (eff_en[g]),
            .mode       (eff_open[g] ? drive_open_drain : drive_push_pull),
            .out_val    (eff_out[g]),
            .pullup_on  (next_pullup[g]),
            .pad_oe     (next_oe[g])
        );
    end

    // transmit pad is always an open drain output
    pad_pullup_cell u_tx (
        .pullup_ctl (1'b1),
        .out_en     (1'b1),
        .mode       (drive_open_drain),
        .out_val    (tx_val),
        .pullup_on  (next_tx_pullup),
        .pad_oe     (next_tx_oe)
    );

    // read mux, status shows synchronised pin levels
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFS_PULLUP_DISABLE: next_prdata[`BIT_PUD_CAN] = pullup_disable_reg;
            `OFS_PORT_E_PULLUP:  next_prdata[NPINS-1:0]   = port_e_pullup_reg;
            `OFS_PORT_E_FUNC:    next_prdata[NPINS-1:0]   = func_gpio;
            `OFS_PORT_E_DIR:     next_prdata[NPINS-1:0]   = port_dir;
            `OFS_PORT_E_DATA:    next_prdata[NPINS-1:0]   = port_data;
            `OFS_PORT_E_OPEN:    next_prdata[NPINS-1:0]   = port_open;
            `OFS_CAN_TX_DATA:    next_prdata[0]           = can_tx_soft;
            `OFS_PAD_STATUS:     next_prdata[NPINS:0]     = {pin_sync, rx_sync};
            default:             next_prdata              = 32'h0000_0000;
        endcase
    end

    // apb answer: no wait state, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : prdata;
        end
    end

    // registered pad outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            can_rx_data    <= 1'b1;
            can_rx_pullup  <= 1'b1;
            can_tx_oe      <= 1'b0;
            can_tx_out     <= 1'b0;
            can_tx_pullup  <= 1'b1;
            timer_in       <= '1;
            port_e_pin_out <= '0;
            port_e_pin_oe  <= '0;
            port_e_pullup  <= '1;
        end
        else
        begin
            can_rx_data    <= rx_sync;
            can_rx_pullup  <= ~pullup_disable_reg;
            can_tx_oe      <= next_tx_oe;
            can_tx_out     <= 1'b0;
            can_tx_pullup  <= next_tx_pullup;
            timer_in       <= pin_sync;
            port_e_pin_out <= eff_out;
            port_e_pin_oe  <= next_oe;
            port_e_pullup  <= next_pullup;
        end
    end
endmodule

// ==== pad_pullup_params.svh ====
// Purpose: offsets, field positions and reset values of the pad pull-up control block
// Assumes: 32-bit apb, word aligned registers
// Notes:   included by bare name
`ifndef PAD_PULLUP_PARAMS_SVH
`define PAD_PULLUP_PARAMS_SVH
`define OFS_PULLUP_DISABLE   12'h000
`define OFS_PORT_E_PULLUP    12'h004
`define OFS_PORT_E_FUNC      12'h008
`define OFS_PORT_E_DIR       12'h00c
`define OFS_PORT_E_DATA      12'h010
`define OFS_PORT_E_OPEN      12'h014
`define OFS_PAD_STATUS       12'h018
`define OFS_CAN_TX_DATA      12'h01c
`define BIT_PUD_CAN          0
`define RST_PULLUP_DISABLE   1'b0
`define RST_PORT_E_PULLUP    2'h3
`define RST_PORT_E_FUNC      2'h0
`define RST_PORT_E_DIR       2'h0
`define RST_PORT_E_DATA      2'h0
`define RST_PORT_E_OPEN      2'h0
`endif

// ==== pad_pullup_pkg.sv ====
// Purpose: types of the pad pull-up control block
// Assumes: nothing
// Notes:   drive modes of a pad
package pad_pullup_pkg;
    typedef enum logic {drive_push_pull, drive_open_drain} drive_mode_t;
endpackage

// ==== pad_pullup_cell.sv ====
// Purpose: effective pull-up and drive of one pad
// Assumes: inputs come from registers on pclk
// Notes:   fully combinational
module pad_pullup_cell
    import pad_pullup_pkg::*;
(
    input  wire logic        pullup_ctl,  // software pull-up permission
    input  wire logic        out_en,      // pad acts as output
    input  wire drive_mode_t mode,        // open drain or push pull
    input  wire logic        out_val,     // value being driven
    output logic             pullup_on,   // effective pull-up enable
    output logic             pad_oe       // pad output enable
);
    // pull-up from control bit, direction, mode and level
    always_comb
    begin
        pullup_on = pullup_ctl;
        pad_oe    = 1'b0;
        if (out_en)
        begin
            if (mode == drive_open_drain)
            begin
                pad_oe    = ~out_val;                // drives only a low
                pullup_on = pullup_ctl & out_val;
            end
            else
            begin
                pad_oe    = 1'b1;
                pullup_on = 1'b0;
            end
        end
    end
endmodule

// ==== pad_pullup_chk.sv ====
// Purpose: assertions on the pad pull-up control ports
// Assumes: pad outputs lag their cause by one pclk edge, except can_rx_data, which lags can_rx_pin by three
// Notes:   bound to the top module after the checker
`include "pad_pullup_params.svh"
module pad_pullup_chk #(
    parameter int NPINS = 2
)
(
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic             pready,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             can_rx_pin,
    input wire logic             can_rx_data,
    input wire logic             can_rx_pullup,
    input wire logic             can_tx_ctl,
    input wire logic             can_tx_oe,
    input wire logic             can_tx_out,
    input wire logic             can_tx_pullup,
    input wire logic [NPINS-1:0] port_e_pin_oe,
    input wire logic [NPINS-1:0] port_e_pullup
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_dis; // completed write to the disable register
    assign wr_dis = psel && penable && pwrite && pready && paddr == `OFS_PULLUP_DISABLE;
    rst_state_a: assert property ($rose(presetn) |-> can_rx_pullup && can_tx_pullup
        && &port_e_pullup && !(|port_e_pin_oe)) else $error("pad state after reset wrong");
    rx_disable_a: assert property (wr_dis |-> ##2 can_rx_pullup == !$past(pwdata[0], 2))
        else $error("receive pull-up ignores disable bit");
    rx_hold_a: assert property (!$past(wr_dis, 2) |-> $stable(can_rx_pullup))
        else $error("receive pull-up moved without a write");
    rx_sync_a: assert property ($past(presetn, 3) |-> can_rx_data == $past(can_rx_pin, 3))
        else $error("receive data not the input pad level");
    tx_low_a: assert property (!$past(can_tx_ctl) && $past(presetn) |-> can_tx_oe && !can_tx_pullup)
        else $error("transmit low keeps its pull-up");
    tx_pair_a: assert property (can_tx_oe != can_tx_pullup) else $error("transmit drive and pull-up clash");
    tx_open_a: assert property (!can_tx_out) else $error("transmit pad drives high");
    port_pull_a: assert property ((port_e_pin_oe & port_e_pullup) == '0)
        else $error("driving port pin keeps pull-up");
    cover property (wr_dis && pwdata[0]);
    cover property (can_tx_oe);
    cover property (port_e_pin_oe == '1);
endmodule
bind pad_pullup_control pad_pullup_chk #(.NPINS(NPINS)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .paddr, .pwdata, .can_rx_pin, .can_rx_data, .can_rx_pullup, .can_tx_ctl, .can_tx_oe, .can_tx_out, .can_tx_pullup,
    .port_e_pin_oe, .port_e_pullup);

// ==== pad_board.sv ====
// Purpose: board model of the pads around the pull-up control block
// Assumes: bus line idles high through its termination
// Notes:   an undriven pad without pull-up wanders every cycle
module pad_board (
    input  wire logic       pclk,
    input  wire logic       can_tx_oe,
    input  wire logic [1:0] port_e_pin_out,
    input  wire logic [1:0] port_e_pin_oe,
    input  wire logic [1:0] port_e_pullup,
    output logic            can_rx_pin,
    output logic [1:0]      port_e_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] drift = 2'b01; // level seen on a floating pad
    // floating pads never hold a level
    always @(posedge pclk)
        drift <= ~drift;
    // bus reads back low only while our transmitter pulls it
    assign can_rx_pin = ~can_tx_oe;
    // driven pad wins, then the pull-up, else it floats
    assign port_e_pin_in = (port_e_pin_oe & port_e_pin_out) | (~port_e_pin_oe & (port_e_pullup | drift));
endmodule

// ==== pad_pullup_control_bench.sv ====
// Purpose: self-checking bench of the pad pull-up control block
// Assumes: board model resolves the pads
// Notes:   read data is checked from a queue at the access edge
`include "pad_pullup_params.svh"
module pad_pullup_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, can_tx_ctl = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic        pready, pslverr, can_rx_pin, can_rx_data, can_rx_pullup, can_tx_oe, can_tx_out, can_tx_pullup;
    logic [1:0]  timer_out = '0, timer_oe = '0, timer_in, port_e_pin_in, port_e_pin_out, port_e_pin_oe, port_e_pullup;
    logic [1:0]  fn, dr, dt, od, pc, om, e_oe, pu, sel; // random port setup and expected drive
    int          errors = 0, checks_done = 0, cycles = 0, seed = 32'he7906865;
    logic [31:0] exp_q[$]; // expected read data in issue order
    pad_pullup_control #(.NPINS(2)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .can_rx_pin, .can_rx_data, .can_rx_pullup, .can_tx_ctl, .can_tx_oe, .can_tx_out,
        .can_tx_pullup, .timer_out, .timer_oe, .timer_in, .port_e_pin_in, .port_e_pin_out, .port_e_pin_oe,
        .port_e_pullup);
    pad_board u_board (.pclk, .can_tx_oe, .port_e_pin_out, .port_e_pin_oe, .port_e_pullup, .can_rx_pin, .port_e_pin_in);
    initial forever #2 pclk = ~pclk;
    task chk(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        errors += int'(seen !== want);
        if (seen !== want) $display("[ERR] %0t seen %h want %h", $time, seen, want);
    endtask
    task final_report(input int extra);
        errors += extra;
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, '0);
    endtask
    // hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000) final_report(1);
    end
    // transfer monitor at the access edge: error flag and read data
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
            chk(pslverr, 1'b0);
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            chk(prdata, exp_q.pop_front());
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        chk({can_rx_pullup, can_tx_pullup, port_e_pullup, port_e_pin_oe}, 6'h3c);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rd(12'(4 * i), i == 1 ? 3 : i == 6 ? 7 : i == 7 ? 1 : 0);
        for (int v = 1; v >= 0; v--)
        begin
            apb(1'b1, `OFS_PULLUP_DISABLE, v);
            repeat (3) @(posedge pclk);
            chk(can_rx_pullup, !v);
        end
        for (int k = 0; k < 4; k++)
        begin
            apb(1'b1, `OFS_CAN_TX_DATA, k / 2);
            can_tx_ctl <= k[0];
            repeat (3) @(posedge pclk);
            chk({can_tx_oe, can_tx_pullup, can_tx_out}, k == 3 ? 3'b010 : 3'b100);
        end
        for (int n = 0; n < 24; n++)
        begin
            r = $random(seed);
            {fn, dr, dt, od, pc} = r[9:0];
            timer_oe <= r[11:10];
            timer_out <= r[13:12];
            apb(1'b1, `OFS_PORT_E_FUNC, fn);
            apb(1'b1, `OFS_PORT_E_DIR, dr);
            apb(1'b1, `OFS_PORT_E_DATA, dt);
            apb(1'b1, `OFS_PORT_E_OPEN, od);
            apb(1'b1, `OFS_PORT_E_PULLUP, pc);
            rd(`OFS_PORT_E_PULLUP, pc);
            repeat (3) @(posedge pclk);
            om = (fn & dr) | (~fn & timer_oe);
            e_oe = om & ~(fn & od & dt);
            chk(port_e_pin_oe, e_oe);
            pu = pc & ~e_oe & ~(om & ~(fn & od));
            sel = (fn & dt) | (~fn & timer_out);
            chk(port_e_pullup, pu);
            chk((port_e_pin_out ^ sel) & e_oe & ~(fn & od), 0);
            // pin level seen back where it is driven or pulled up, floating bits masked
            chk(timer_in & (e_oe | pu), ((e_oe & sel) | pu) & (e_oe | pu));
        end
        // reset again with the port reprogrammed: defaults must come back
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({can_rx_pullup, can_tx_pullup, port_e_pullup, port_e_pin_oe}, 6'h3c);
        presetn <= 1'b1;
        rd(`OFS_PORT_E_FUNC, 0);
        rd(`OFS_PORT_E_PULLUP, 3);
        @(posedge pclk);
        final_report(exp_q.size());
    end
endmodule
